// ===== cor_regs.svh
// constants of the core operational register set
// Behaviour
// - address 00h reaches data pointed indirectly
// - tick counter counts pin edges or cycles
// - tick counter reads and writes like RAM
// - program counter spans 4K words of ROM
// - jump loads low ten counter bits
// - call pushes next address, loads low ten
// - returns load full counter from stack top
// - move to 02h loads counter, keeps 9,8
// - add to 02h offsets the counter
// - jumps, calls, moves and adds copy page bits to top
// - returns never modify the page bits
// - power-down flag set power/clear, cleared sleep
// - timeout/power-down pairs follow wake cause
// - status holds zero, half carry, carry
// - bits 7..6 of pointer pick bank
// - bits 5..0 point indirect, else plain storage
// - bit 0 of 05h picks control page
`ifndef COR_REGS_SVH
`define COR_REGS_SVH
`define COR_ADDR_IND 6'h00
`define COR_ADDR_TICK 6'h01
`define COR_ADDR_PCL 6'h02
`define COR_ADDR_STAT 6'h03
`define COR_ADDR_RSEL 6'h04
`define COR_ADDR_PORT 6'h05
`define COR_ADDR_FIRST_RAM 6'h06
`define COR_TICK_RST 8'h00
`define COR_STAT_RST 8'h18
`define COR_RSEL_RST 8'h00
`define COR_PORT_RST 8'h00
`define COR_PC_RST 12'h000
`define COR_SB_PAGE_HI 6
`define COR_SB_PAGE_LO 5
`define COR_SB_TIMEOUT 4
`define COR_SB_PWRDN 3
`define COR_SB_ZERO 2
`define COR_SB_CARRY 0
`define COR_RB_BANK_HI 7
`define COR_RB_BANK_LO 6
`define COR_RB_PTR_HI 5
`define COR_PB_PAGE 0
`define COR_PB_DATA_HI 7
`define COR_PB_DATA_LO 4
`define COR_PC_PAGE_LO 10
`define COR_PC_KEEP_LO 8
`endif

// ===== cor_pkg.sv
// types shared by the core register set
package cor_pkg;
	typedef logic [11:0] cor_pc_t;
	typedef enum logic [2:0] {
		COR_PC_HOLD,
		COR_PC_STEP,
		COR_PC_JUMP,
		COR_PC_CALL,
		COR_PC_EXIT,
		COR_PC_MOVE,
		COR_PC_ADD
	} cor_pc_op_e;
endpackage

// ===== cor_pc_if.sv
// program counter control bundle
`timescale 1ns/1ns
interface cor_pc_if;
	cor_pkg::cor_pc_op_e op;
	logic [1:0] page;
	logic [9:0] operand;
	logic [7:0] acc;
	cor_pkg::cor_pc_t stack_top;
	cor_pkg::cor_pc_t pc;
	cor_pkg::cor_pc_t push_addr;
	modport ctrl (output op, page, operand, acc, stack_top,
		input pc, push_addr);
	modport unit (input op, page, operand, acc, stack_top,
		output pc, push_addr);
endinterface

// ===== cor_tick.sv
// tick counter with cycle or pin-edge source
`timescale 1ns/1ns
`include "cor_regs.svh"
module cor_tick #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic src_ext,
	input wire logic pin,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] count
);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic pin_reg;
	logic pin_next;
	if (WIDTH != 8)
	begin : g_bad_width
		$error("tick counter must be 8 bits wide");
	end
	always_comb
	begin
		pin_next = pin;
		count_next = count_reg;
		// a write in the same cycle as a tick wins
		if (wr_en)
			count_next = wr_data;
		else if (!src_ext || (pin && !pin_reg))
			count_next = count_reg + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count_reg <= `COR_TICK_RST;
			pin_reg <= 1'b0;
		end
		else
		begin
			count_reg <= count_next;
			pin_reg <= pin_next;
		end
	end
	assign count = count_reg;
	a_tick_write: assert property (@(posedge clk) disable iff (rst)
		wr_en |=> count == $past(wr_data))
		else $error("tick write not stored");
	a_tick_cycle: assert property (@(posedge clk) disable iff (rst)
		!wr_en && !src_ext |=> count == $past(count) + 1'b1)
		else $error("tick missed a cycle count");
	a_tick_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_en && src_ext && !(pin && !pin_reg) |=> $stable(count))
		else $error("tick moved without a pin edge");
endmodule

// ===== cor_pc.sv
// program counter with page extension and step
`timescale 1ns/1ns
`include "cor_regs.svh"
module cor_pc #(
	parameter int ADDR_W = 12
) (
	input wire logic clk,
	input wire logic rst,
	cor_pc_if.unit pcif
);
	cor_pkg::cor_pc_t pc_reg;
	cor_pkg::cor_pc_t pc_next;
	logic [9:0] low_sum;
	if (ADDR_W != 12)
	begin : g_bad_addr
		$error("program counter must cover exactly 4K words");
	end
	always_comb
	begin
		pc_next = pc_reg;
		low_sum = 10'h000;
		case (pcif.op)
			cor_pkg::COR_PC_HOLD:
				pc_next = pc_reg;
			cor_pkg::COR_PC_STEP:
			begin
				// wraps inside the current page
				low_sum = pc_reg[9:0] + 10'h001;
				pc_next = {pc_reg[11:`COR_PC_PAGE_LO], low_sum};
			end
			cor_pkg::COR_PC_JUMP, cor_pkg::COR_PC_CALL:
				pc_next = {pcif.page, pcif.operand};
			cor_pkg::COR_PC_EXIT:
				pc_next = pcif.stack_top;
			cor_pkg::COR_PC_MOVE:
				pc_next = {pcif.page, pc_reg[9:`COR_PC_KEEP_LO],
					pcif.acc};
			cor_pkg::COR_PC_ADD:
			begin
				low_sum = pc_reg[9:0] + {2'b00, pcif.acc};
				pc_next = {pcif.page, low_sum};
			end
			default:
				pc_next = pc_reg;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			pc_reg <= `COR_PC_RST;
		else
			pc_reg <= pc_next;
	end
	assign pcif.pc = pc_reg;
	assign pcif.push_addr = pc_reg + 12'h001;
	a_pc_jump: assert property (@(posedge clk) disable iff (rst)
		pcif.op == cor_pkg::COR_PC_JUMP |=>
		pcif.pc == {$past(pcif.page), $past(pcif.operand)})
		else $error("jump target wrong");
	a_pc_exit: assert property (@(posedge clk) disable iff (rst)
		pcif.op == cor_pkg::COR_PC_EXIT |=>
		pcif.pc == $past(pcif.stack_top))
		else $error("return target wrong");
	a_pc_move: assert property (@(posedge clk) disable iff (rst)
		pcif.op == cor_pkg::COR_PC_MOVE |=>
		pcif.pc[9:8] == $past(pcif.pc[9:8])
		&& pcif.pc[7:0] == $past(pcif.acc))
		else $error("move into counter wrong");
	a_pc_step: assert property (@(posedge clk) disable iff (rst)
		pcif.op == cor_pkg::COR_PC_STEP |=>
		pcif.pc[11:10] == $past(pcif.pc[11:10])
		&& pcif.pc[9:0] == $past(pcif.pc[9:0]) + 10'h001)
		else $error("step left the page");
endmodule

// ===== cor_regfile.sv
// core operational registers at data addresses 00h..05h
`timescale 1ns/1ns
`include "cor_regs.svh"
module cor_regfile (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [5:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic [7:0] RAM_ADDR,
	output logic RAM_WR,
	output logic [7:0] RAM_WDATA,
	input wire logic [7:0] RAM_RDATA,
	input wire logic TICK_PIN,
	input wire logic TICK_SRC_EXT,
	input wire logic JUMP_EN,
	input wire logic CALL_EN,
	input wire logic EXIT_EN,
	input wire logic ADD_PC_EN,
	input wire logic STEP_EN,
	input wire logic [7:0] ACC,
	input wire logic [9:0] OPERAND,
	input wire logic [11:0] STACK_TOP,
	output logic PUSH_EN,
	output logic [11:0] PUSH_ADDR,
	output logic [11:0] PC,
	input wire logic PAGE_EN,
	input wire logic [1:0] PAGE_SEL,
	input wire logic BANK_EN,
	input wire logic [1:0] BANK_SEL,
	input wire logic ALU_FLAGS_EN,
	input wire logic [2:0] ALU_FLAGS,
	input wire logic SLEEP_INSTR,
	input wire logic WATCHDOG_CLEAR_INSTR,
	input wire logic WATCHDOG_TIMEOUT,
	input wire logic PIN_RESET,
	output logic SLEEPING,
	output logic [3:0] PORT_NIBBLE,
	output logic CTRL_PAGE
);
	cor_pc_if pcif ();

	logic [7:0] stat_reg;
	logic [7:0] stat_next;
	logic [7:0] rsel_reg;
	logic [7:0] rsel_next;
	logic [7:0] port_reg;
	logic [7:0] port_next;
	logic sleep_reg;
	logic sleep_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [5:0] eff_addr;
	logic is_ram;
	logic wr_tick;
	logic wr_pcl;
	logic wr_stat;
	logic wr_rsel;
	logic wr_port;
	logic [7:0] tick_count;
	logic [1:0] page_bits;

	// address 00h is a window onto the pointed location
	always_comb
	begin
		if (REG_ADDR == `COR_ADDR_IND)
			eff_addr = rsel_reg[`COR_RB_PTR_HI:0];
		else
			eff_addr = REG_ADDR;
	end

	// a pointer of zero lands on the window itself and reaches nothing
	assign is_ram = (eff_addr >= `COR_ADDR_FIRST_RAM);
	assign wr_tick = REG_WR && (eff_addr == `COR_ADDR_TICK);
	assign wr_pcl = REG_WR && (eff_addr == `COR_ADDR_PCL);
	assign wr_stat = REG_WR && (eff_addr == `COR_ADDR_STAT);
	assign wr_rsel = REG_WR && (eff_addr == `COR_ADDR_RSEL);
	assign wr_port = REG_WR && (eff_addr == `COR_ADDR_PORT);

	assign RAM_ADDR = {rsel_reg[`COR_RB_BANK_HI:`COR_RB_BANK_LO],
		eff_addr};
	assign RAM_WR = REG_WR && is_ram;
	assign RAM_WDATA = REG_WDATA;

	cor_tick #(
		.WIDTH(8)
	) u_tick (
		.clk(CLOCK),
		.rst(RESET),
		.src_ext(TICK_SRC_EXT),
		.pin(TICK_PIN),
		.wr_en(wr_tick),
		.wr_data(REG_WDATA),
		.count(tick_count)
	);

	assign page_bits = stat_reg[`COR_SB_PAGE_HI:`COR_SB_PAGE_LO];

	// one counter change per cycle: returns first, a plain step last
	always_comb
	begin
		if (EXIT_EN)
			pcif.op = cor_pkg::COR_PC_EXIT;
		else if (CALL_EN)
			pcif.op = cor_pkg::COR_PC_CALL;
		else if (JUMP_EN)
			pcif.op = cor_pkg::COR_PC_JUMP;
		else if (wr_pcl)
			pcif.op = cor_pkg::COR_PC_MOVE;
		else if (ADD_PC_EN)
			pcif.op = cor_pkg::COR_PC_ADD;
		else if (STEP_EN)
			pcif.op = cor_pkg::COR_PC_STEP;
		else
			pcif.op = cor_pkg::COR_PC_HOLD;
	end
	assign pcif.page = page_bits;
	assign pcif.operand = OPERAND;
	assign pcif.acc = wr_pcl ? REG_WDATA : ACC;
	assign pcif.stack_top = STACK_TOP;

	cor_pc #(
		.ADDR_W(12)
	) u_pc (
		.clk(CLOCK),
		.rst(RESET),
		.pcif(pcif)
	);

	assign PC = pcif.pc;
	assign PUSH_ADDR = pcif.push_addr;
	assign PUSH_EN = CALL_EN && !EXIT_EN;

	// sleep state tells a wake apart from a reset while running
	always_comb
	begin
		sleep_next = sleep_reg;
		if (WATCHDOG_TIMEOUT || PIN_RESET)
			sleep_next = 1'b0;
		if (SLEEP_INSTR)
			sleep_next = 1'b1;
	end

	// status: page and arithmetic flags writable, T and P hardware only
	always_comb
	begin
		stat_next = stat_reg;
		if (wr_stat)
		begin
			stat_next[`COR_SB_PAGE_HI:`COR_SB_PAGE_LO] =
				REG_WDATA[`COR_SB_PAGE_HI:`COR_SB_PAGE_LO];
			stat_next[`COR_SB_ZERO:`COR_SB_CARRY] =
				REG_WDATA[`COR_SB_ZERO:`COR_SB_CARRY];
		end
		if (PAGE_EN)
			stat_next[`COR_SB_PAGE_HI:`COR_SB_PAGE_LO] = PAGE_SEL;
		if (ALU_FLAGS_EN)
			stat_next[`COR_SB_ZERO:`COR_SB_CARRY] = ALU_FLAGS;
		if (WATCHDOG_TIMEOUT)
		begin
			stat_next[`COR_SB_TIMEOUT] = 1'b0;
			if (!sleep_reg)
				stat_next[`COR_SB_PWRDN] = 1'b1;
		end
		if (SLEEP_INSTR)
			stat_next[`COR_SB_PWRDN] = 1'b0;
		if (PIN_RESET)
			stat_next[`COR_SB_PWRDN] = !sleep_reg;
		if (WATCHDOG_CLEAR_INSTR)
			stat_next[`COR_SB_PWRDN] = 1'b1;
		// setting events win over a timeout in the same cycle
		if (SLEEP_INSTR || WATCHDOG_CLEAR_INSTR || PIN_RESET)
			stat_next[`COR_SB_TIMEOUT] = 1'b1;
		stat_next[7] = 1'b0;
	end

	always_comb
	begin
		rsel_next = rsel_reg;
		if (wr_rsel)
			rsel_next = REG_WDATA;
		if (BANK_EN)
			rsel_next[`COR_RB_BANK_HI:`COR_RB_BANK_LO] = BANK_SEL;
	end

	always_comb
	begin
		port_next = port_reg;
		if (wr_port)
		begin
			port_next[`COR_PB_DATA_HI:`COR_PB_DATA_LO] =
				REG_WDATA[`COR_PB_DATA_HI:`COR_PB_DATA_LO];
			port_next[`COR_PB_PAGE] = REG_WDATA[`COR_PB_PAGE];
		end
		port_next[3:1] = 3'h0;
	end

	// read data lags the request by one cycle
	always_comb
	begin
		rdata_next = rdata_reg;
		if (REG_RD)
		begin
			if (is_ram)
				rdata_next = RAM_RDATA;
			else
			begin
				case (eff_addr)
					`COR_ADDR_TICK:
						rdata_next = tick_count;
					`COR_ADDR_PCL:
						rdata_next = pcif.pc[7:0];
					`COR_ADDR_STAT:
						rdata_next = stat_reg;
					`COR_ADDR_RSEL:
						rdata_next = rsel_reg;
					`COR_ADDR_PORT:
						rdata_next = port_reg;
					default:
						rdata_next = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			stat_reg <= `COR_STAT_RST;
			rsel_reg <= `COR_RSEL_RST;
			port_reg <= `COR_PORT_RST;
			sleep_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			stat_reg <= stat_next;
			rsel_reg <= rsel_next;
			port_reg <= port_next;
			sleep_reg <= sleep_next;
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA = rdata_reg;
	assign SLEEPING = sleep_reg;
	assign PORT_NIBBLE = port_reg[`COR_PB_DATA_HI:`COR_PB_DATA_LO];
	assign CTRL_PAGE = port_reg[`COR_PB_PAGE];

	a_window_to_ram: assert property (@(posedge CLOCK) disable iff (RESET)
		REG_WR && REG_ADDR == 6'h00 && rsel_reg[5:0] >= 6'h06
		|-> RAM_WR && RAM_ADDR == rsel_reg)
		else $error("window write did not reach data memory");

	a_window_no_reg: assert property (@(posedge CLOCK) disable iff (RESET)
		REG_WR && REG_ADDR == 6'h00 && rsel_reg[5:0] == 6'h00
		&& !BANK_EN |=> $stable(rsel_reg))
		else $error("window write touched a register");

	a_timeout_clear: assert property (@(posedge CLOCK) disable iff (RESET)
		WATCHDOG_TIMEOUT && !SLEEP_INSTR && !WATCHDOG_CLEAR_INSTR
		&& !PIN_RESET |=> stat_reg[4] == 1'b0)
		else $error("timeout flag not cleared");

	a_sleep_flags: assert property (@(posedge CLOCK) disable iff (RESET)
		SLEEP_INSTR && !WATCHDOG_CLEAR_INSTR && !PIN_RESET
		|=> stat_reg[4:3] == 2'b10 && SLEEPING)
		else $error("sleep did not give flags 1,0");

	a_watch_wake: assert property (@(posedge CLOCK) disable iff (RESET)
		SLEEP_INSTR ##1 (!SLEEP_INSTR && !WATCHDOG_CLEAR_INSTR
		&& !PIN_RESET && !WATCHDOG_TIMEOUT) ##1 (!SLEEP_INSTR
		&& !WATCHDOG_CLEAR_INSTR && !PIN_RESET && WATCHDOG_TIMEOUT)
		|=> stat_reg[4:3] == 2'b00 && !SLEEPING)
		else $error("watchdog wake flags wrong");

	a_pin_wake: assert property (@(posedge CLOCK) disable iff (RESET)
		PIN_RESET && SLEEPING && !WATCHDOG_CLEAR_INSTR
		&& !SLEEP_INSTR |=> stat_reg[4:3] == 2'b10)
		else $error("pin wake flags wrong");

	a_clear_flags: assert property (@(posedge CLOCK) disable iff (RESET)
		WATCHDOG_CLEAR_INSTR |=> stat_reg[4:3] == 2'b11)
		else $error("watchdog clear flags wrong");

	a_status_top: assert property (@(posedge CLOCK) disable iff (RESET)
		ALU_FLAGS_EN |=> stat_reg[7] == 1'b0
		&& stat_reg[2:0] == $past(ALU_FLAGS))
		else $error("status flags misplaced");

	a_bank_select: assert property (@(posedge CLOCK) disable iff (RESET)
		BANK_EN |=> rsel_reg[7:6] == $past(BANK_SEL)
		&& RAM_ADDR[7:6] == $past(BANK_SEL))
		else $error("bank select not applied");

	a_page_copy: assert property (@(posedge CLOCK) disable iff (RESET)
		CALL_EN && !EXIT_EN |=> PC == {$past(page_bits), $past(OPERAND)}
		&& $past(PUSH_ADDR) == $past(PC) + 12'h001)
		else $error("call target or push address wrong");

	a_exit_page: assert property (@(posedge CLOCK) disable iff (RESET)
		EXIT_EN && !PAGE_EN && !wr_stat |=> $stable(page_bits))
		else $error("return changed the page bits");

	a_ctrl_page: assert property (@(posedge CLOCK) disable iff (RESET)
		wr_port |=> CTRL_PAGE == $past(REG_WDATA[0])
		&& PORT_NIBBLE == $past(REG_WDATA[7:4]))
		else $error("port or control page not stored");
endmodule

// ===== cor_regfile_tb.sv
// self-checking bench for the core operational register set
`timescale 1ns/1ns
module cor_regfile_tb;
	localparam logic [13:0] F_WR = 14'h2000;
	localparam logic [13:0] F_RD = 14'h1000;
	localparam logic [13:0] F_JUMP = 14'h0800;
	localparam logic [13:0] F_CALL = 14'h0400;
	localparam logic [13:0] F_EXIT = 14'h0200;
	localparam logic [13:0] F_ADD = 14'h0100;
	localparam logic [13:0] F_STEP = 14'h0080;
	localparam logic [13:0] F_PAGE = 14'h0040;
	localparam logic [13:0] F_BANK = 14'h0020;
	localparam logic [13:0] F_ALU = 14'h0010;
	localparam logic [13:0] F_SLP = 14'h0008;
	localparam logic [13:0] F_WDC = 14'h0004;
	localparam logic [13:0] F_WTO = 14'h0002;
	localparam logic [13:0] F_PRS = 14'h0001;
	logic CLOCK = 1'b0;
	logic RESET = 1'b1;
	logic [5:0] REG_ADDR = 6'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic [13:0] pul = 14'h0000;
	logic TICK_PIN = 1'b0;
	logic TICK_SRC_EXT = 1'b1;
	logic [7:0] ACC = 8'h00;
	logic [9:0] OPERAND = 10'h000;
	logic [11:0] STACK_TOP = 12'h000;
	logic [1:0] PAGE_SEL = 2'h0;
	logic [1:0] BANK_SEL = 2'h0;
	logic [2:0] ALU_FLAGS = 3'h0;
	logic [7:0] REG_RDATA;
	logic [7:0] RAM_ADDR;
	logic RAM_WR;
	logic [7:0] RAM_WDATA;
	logic [7:0] ram_rdata;
	logic PUSH_EN;
	logic [11:0] PUSH_ADDR;
	logic [11:0] PC;
	logic SLEEPING;
	logic [3:0] PORT_NIBBLE;
	logic CTRL_PAGE;
	logic [7:0] mem [256];
	logic [7:0] rd_q [$];
	logic [11:0] pc_q [$];
	logic rd_flag = 1'b0;
	logic pc_flag = 1'b0;
	int fails = 0;
	int num_checks = 0;
	int cycles = 0;
	logic [1:0] exp_page;
	logic [2:0] exp_flags;
	logic [11:0] exp_pc;
	logic [11:0] s;
	logic [7:0] v;
	logic [7:0] d;
	logic [5:0] ptr;
	logic [1:0] bk;
	logic [13:0] ev [7] = '{F_SLP, F_WTO, F_WDC, F_WTO, F_SLP, F_PRS, F_PRS};
	logic [1:0] tp [7] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h2, 2'h2, 2'h3};
	logic sl [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

	// ram model answers in the same cycle as the address
	assign ram_rdata = mem[RAM_ADDR];

	cor_regfile i_dut (
		.CLOCK(CLOCK), .RESET(RESET), .REG_ADDR(REG_ADDR),
		.REG_WR(pul[13]), .REG_RD(pul[12]), .REG_WDATA(REG_WDATA),
		.REG_RDATA(REG_RDATA), .RAM_ADDR(RAM_ADDR), .RAM_WR(RAM_WR),
		.RAM_WDATA(RAM_WDATA), .RAM_RDATA(ram_rdata),
		.TICK_PIN(TICK_PIN), .TICK_SRC_EXT(TICK_SRC_EXT),
		.JUMP_EN(pul[11]), .CALL_EN(pul[10]), .EXIT_EN(pul[9]),
		.ADD_PC_EN(pul[8]), .STEP_EN(pul[7]), .ACC(ACC),
		.OPERAND(OPERAND), .STACK_TOP(STACK_TOP), .PUSH_EN(PUSH_EN),
		.PUSH_ADDR(PUSH_ADDR), .PC(PC), .PAGE_EN(pul[6]),
		.PAGE_SEL(PAGE_SEL), .BANK_EN(pul[5]), .BANK_SEL(BANK_SEL),
		.ALU_FLAGS_EN(pul[4]), .ALU_FLAGS(ALU_FLAGS),
		.SLEEP_INSTR(pul[3]), .WATCHDOG_CLEAR_INSTR(pul[2]),
		.WATCHDOG_TIMEOUT(pul[1]), .PIN_RESET(pul[0]),
		.SLEEPING(SLEEPING), .PORT_NIBBLE(PORT_NIBBLE),
		.CTRL_PAGE(CTRL_PAGE)
	);

	always #2 CLOCK = ~CLOCK;

	always @(posedge CLOCK)
	begin
		if (RAM_WR)
			mem[RAM_ADDR] <= RAM_WDATA;
	end

	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH read_data expected %h seen %h", e, g);
		end
	endtask

	task automatic chk_pc(input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH pc expected %h seen %h", e, g);
		end
	endtask

	task automatic chk_out(input string n, input logic [11:0] e,
		input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	// results are checked one cycle after the edge that took the request
	always @(posedge CLOCK)
	begin
		if (rd_flag)
			chk_rd(rd_q.pop_front(), REG_RDATA);
		if (pc_flag)
			chk_pc(pc_q.pop_front(), PC);
		rd_flag <= pul[12];
		pc_flag <= (|pul[11:7]) | (pul[13] & (REG_ADDR == 6'h02));
	end

	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// whole run needs under a hundred cycles
	always @(posedge CLOCK)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			end_of_test;
		end
	end

	task cyc(input logic [13:0] p);
		pul <= p;
		@(posedge CLOCK);
	endtask

	task wr(input logic [5:0] a, input logic [7:0] w);
		REG_ADDR <= a;
		REG_WDATA <= w;
		cyc(F_WR);
	endtask

	task rd(input logic [5:0] a, input logic [7:0] e);
		REG_ADDR <= a;
		rd_q.push_back(e);
		cyc(F_RD);
	endtask

	task pc_op(input logic [13:0] p, input logic [11:0] e);
		pc_q.push_back(e);
		exp_pc = e;
		cyc(p);
	endtask

	function automatic logic [7:0] st(input logic [1:0] t_p);
		return {1'b0, exp_page, t_p, exp_flags};
	endfunction

	initial
	begin
		void'($urandom(32'h208fd6a8));
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i) ^ 8'h5A;
		exp_page = 2'h0;
		exp_flags = 3'h0;
		exp_pc = 12'h000;
		repeat (3) @(posedge CLOCK);
		RESET <= 1'b0;
		rd(6'h01, 8'h00);
		rd(6'h03, st(2'h3));
		rd(6'h04, 8'h00);
		rd(6'h05, 8'h00);
		rd(6'h02, 8'h00);
		$display("test reset done");
		v = 8'($urandom);
		wr(6'h01, v);
		TICK_PIN <= 1'b1;
		repeat (3) cyc(14'h0000);
		rd(6'h01, v + 8'h01);
		TICK_PIN <= 1'b0;
		cyc(14'h0000);
		rd(6'h01, v + 8'h01);
		d = 8'($urandom);
		TICK_SRC_EXT <= 1'b0;
		wr(6'h01, d);
		rd(6'h01, d);
		rd(6'h01, d + 8'h01);
		TICK_SRC_EXT <= 1'b1;
		$display("test tick done");
		ptr = 6'h06 + 6'($urandom % 58);
		bk = 2'($urandom);
		wr(6'h04, {bk, ptr});
		rd(6'h04, {bk, ptr});
		d = 8'($urandom);
		wr(6'h00, d);
		rd(6'h00, d);
		rd(ptr, d);
		BANK_SEL <= bk + 2'h1;
		cyc(F_BANK);
		rd(6'h04, {bk + 2'h1, ptr});
		rd(6'h00, {bk + 2'h1, ptr} ^ 8'h5A);
		wr(6'h04, 8'h00);
		wr(6'h00, 8'hFF);
		rd(6'h00, 8'h00);
		chk_out("ram_word0", 12'h05A, 12'(mem[0]));
		$display("test indirect done");
		v = 8'($urandom);
		wr(6'h05, v);
		rd(6'h05, v & 8'hF1);
		chk_out("ctrl_page", 12'(v[0]), 12'(CTRL_PAGE));
		chk_out("port_data", 12'(v[7:4]), 12'(PORT_NIBBLE));
		$display("test port done");
		for (int i = 0; i < 7; i++)
		begin
			cyc(ev[i]);
			rd(6'h03, st(tp[i]));
			chk_out("sleeping", 12'(sl[i]), 12'(SLEEPING));
		end
		wr(6'h03, 8'hFF);
		exp_page = 2'h3;
		exp_flags = 3'h7;
		rd(6'h03, 8'h7F);
		v = 8'($urandom);
		ALU_FLAGS <= v[2:0];
		cyc(F_ALU);
		exp_flags = v[2:0];
		rd(6'h03, st(2'h3));
		$display("test status done");
		PAGE_SEL <= 2'h2;
		cyc(F_PAGE);
		exp_page = 2'h2;
		OPERAND <= 10'h3FF;
		pc_op(F_JUMP, 12'hBFF);
		pc_op(F_STEP, 12'h800);
		v = 8'($urandom);
		OPERAND <= {2'h1, v};
		pc_q.push_back({2'h2, 2'h1, v});
		pul <= F_CALL;
		#1;
		chk_out("push_en", 12'h001, 12'(PUSH_EN));
		chk_out("push_addr", 12'h801, PUSH_ADDR);
		exp_pc = {2'h2, 2'h1, v};
		@(posedge CLOCK);
		s = 12'($urandom);
		STACK_TOP <= s;
		pc_op(F_EXIT, s);
		rd(6'h03, st(2'h3));
		STACK_TOP <= ~s;
		pc_q.push_back(~s);
		pul <= F_CALL | F_EXIT;
		#1;
		chk_out("push_en", 12'h000, 12'(PUSH_EN));
		exp_pc = ~s;
		@(posedge CLOCK);
		d = 8'($urandom);
		pc_q.push_back({exp_page, exp_pc[9:8], d});
		exp_pc = {exp_page, exp_pc[9:8], d};
		wr(6'h02, d);
		rd(6'h02, d);
		v = 8'($urandom);
		ACC <= v;
		pc_op(F_ADD, {exp_page, exp_pc[9:0] + {2'h0, v}});
		repeat (2) cyc(14'h0000);
		$display("test counter done");
		end_of_test;
	end
endmodule
